// file: src/idd_defines.svh
`ifndef IDD_DEFINES_SVH
`define IDD_DEFINES_SVH

// field start positions, counted from the leftmost word bit as 0
`define IDD_POS_FUNC 8'h00
`define IDD_POS_SUBF 8'h08
`define IDD_POS_REG1 8'h08
`define IDD_POS_REG2 8'h10
`define IDD_POS_REG3 8'h18
`define IDD_POS_REG4 8'h20
`define IDD_POS_REG5 8'h28
`define IDD_POS_REG6 8'h30
`define IDD_POS_REG7 8'h38
`define IDD_POS_IMM 8'h10
`define IDD_POS_BITSEL 8'h12
// field lengths in bits
`define IDD_LEN_BYTE 8'h08
`define IDD_LEN_IMM48 8'h30
`define IDD_LEN_IMM24 8'h18
`define IDD_LEN_IMM16 8'h10
`define IDD_LEN_BITSEL 8'h06
`define IDD_WORD_BITS 8'h40
// selector bit that marks a long word
`define IDD_LONG_BIT 7
// masks of meaningful subfunction bits
`define IDD_SUBF_ALL 8'hFF
`define IDD_SUBF_NONE 8'h00
// operation selectors with special field handling
`define IDD_OP_B0 8'hB0
`define IDD_OP_B5 8'hB5
`define IDD_OP_B6 8'hB6
`define IDD_OP_BE 8'hBE
`define IDD_OP_BF 8'hBF
`define IDD_OP_CD 8'hCD
`define IDD_OP_CE 8'hCE
`define IDD_OP_3E 8'h3E
`define IDD_OP_3F 8'h3F
`define IDD_OP_4D 8'h4D
`define IDD_OP_4E 8'h4E
`define IDD_OP_2A 8'h2A
`define IDD_OP_3D 8'h3D
`define IDD_OP_32 8'h32
`define IDD_OP_33 8'h33
`define IDD_OP_SPV_LO 8'hA0
`define IDD_OP_SPV_HI 8'hAF
// indices into the register-valid vector
`define IDD_RV_A 0
`define IDD_RV_B 1
`define IDD_RV_C 2
`define IDD_RV_X 3
`define IDD_RV_Y 4
`define IDD_RV_Z 5
`define IDD_RV_R 6
`define IDD_RV_S 7
`define IDD_RV_T 8
`define IDD_RV_NUM 9

`endif

// file: src/idd_pkg.sv
`default_nettype none
package idd_pkg;
  // instruction format types
  typedef enum logic [3:0] {
    IDD_FMT_NONE = 4'h0, IDD_FMT_1 = 4'h1, IDD_FMT_2 = 4'h2, IDD_FMT_3 = 4'h3,
    IDD_FMT_4 = 4'h4, IDD_FMT_5 = 4'h5, IDD_FMT_6 = 4'h6, IDD_FMT_7 = 4'h7,
    IDD_FMT_8 = 4'h8, IDD_FMT_9 = 4'h9, IDD_FMT_A = 4'hA, IDD_FMT_B = 4'hB,
    IDD_FMT_C = 4'hC
  } idd_fmt_t;
  // how the immediate field is taken
  typedef enum logic [2:0] {
    IDD_IMM_NONE = 3'h0, IDD_IMM_BRIDX48 = 3'h1, IDD_IMM_OPND24 = 3'h2,
    IDD_IMM_OPND48 = 3'h3, IDD_IMM_OPND16 = 3'h4, IDD_IMM_BITSEL = 3'h5
  } idd_imm_t;
  // meaning of the z register field
  typedef enum logic [2:0] {
    IDD_Z_NONE = 3'h0, IDD_Z_CTLVEC = 3'h1, IDD_Z_ORDVEC = 3'h2,
    IDD_Z_RESIDX = 3'h3, IDD_Z_CMPOPND = 3'h4
  } idd_zrole_t;
  typedef logic [7:0] idd_reg_t;
  // all decoder state
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic defined;
    logic long_word;
    idd_fmt_t fmt;
    logic [7:0] subf;
    logic [7:0] subf_used;
    idd_imm_t imm_kind;
    logic [47:0] imm;
    logic [5:0] bit_sel;
    idd_reg_t reg_a;
    idd_reg_t reg_b;
    idd_reg_t reg_c;
    idd_reg_t reg_x;
    idd_reg_t reg_y;
    idd_reg_t reg_z;
    idd_reg_t reg_r;
    idd_reg_t reg_s;
    idd_reg_t reg_t;
    logic [8:0] reg_valid;
    idd_zrole_t z_role;
    logic r_is_dest;
    logic r_item_count;
    logic t_is_dest;
    logic t_old_state;
    logic t_base_addr;
    logic signed48;
  } idd_state_t;
endpackage : idd_pkg
`default_nettype wire

// file: src/idd_fmt_if.sv
`default_nettype none
interface idd_fmt_if;
  import idd_pkg::*;
  logic [7:0] opcode;
  idd_fmt_t fmt;
  logic defined;
  logic long_word;
  logic [7:0] subf_used;
  modport lookup (input opcode, output fmt, output defined, output long_word,
                  output subf_used);
  modport user (output opcode, input fmt, input defined, input long_word,
                input subf_used);
endinterface : idd_fmt_if
`default_nettype wire

// file: src/idd_fmt_lookup.sv
`include "idd_defines.svh"
`default_nettype none
module idd_fmt_lookup
  import idd_pkg::*;
(
  idd_fmt_if.lookup fmt_bus
);
  // ************************************************************
  // selector to format table
  // ************************************************************
  // codes not listed fall to undefined
  function automatic idd_fmt_t fmt_of(input logic [7:0] op);
    idd_fmt_t f;
    f = IDD_FMT_NONE;
    case (op)
      8'h00, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0A,
      8'h0C, 8'h0D, 8'h0E, 8'h0F, `IDD_OP_3D: f = IDD_FMT_4;
      8'h06, 8'h12, 8'h13, 8'h14: f = IDD_FMT_7;
      8'h10, 8'h11: f = IDD_FMT_A;
      `IDD_OP_32: f = IDD_FMT_9;
      `IDD_OP_33: f = IDD_FMT_B;
      `IDD_OP_3E, `IDD_OP_3F, `IDD_OP_4D, `IDD_OP_4E, `IDD_OP_2A: f = IDD_FMT_6;
      `IDD_OP_B6, `IDD_OP_BE, `IDD_OP_BF, `IDD_OP_CD, `IDD_OP_CE: f = IDD_FMT_5;
      default:
      begin
        if (op >= `IDD_OP_B0 && op <= `IDD_OP_B5)
          f = IDD_FMT_C;
        else if (op >= `IDD_OP_SPV_LO && op <= `IDD_OP_SPV_HI)
          f = IDD_FMT_2;
        else
          f = IDD_FMT_NONE;
      end
    endcase
    return f;
  endfunction

  // ************************************************************
  // outputs
  // ************************************************************
  // selector class and meaningful subfunction bits
  always_comb
  begin
    fmt_bus.fmt = fmt_of(fmt_bus.opcode);
    fmt_bus.defined = (fmt_bus.fmt != IDD_FMT_NONE);
    fmt_bus.long_word = fmt_bus.opcode[`IDD_LONG_BIT];
    case (fmt_bus.fmt)
      IDD_FMT_1, IDD_FMT_2, IDD_FMT_3, IDD_FMT_9, IDD_FMT_B, IDD_FMT_C:
        fmt_bus.subf_used = `IDD_SUBF_ALL;
      default:
        fmt_bus.subf_used = `IDD_SUBF_NONE;
    endcase
  end
endmodule // idd_fmt_lookup
`default_nettype wire

// file: src/idd_decoder.sv
`include "idd_defines.svh"
`default_nettype none
// How it works
// - the operation selector is the leftmost eight bits of every word
// - all 256 selectors accepted; undefined ones flagged by a defined output
// - formats 1,2,3,9,B,C carry an 8-bit subfunction field for variants
// - subfunction occupies word bits 8..15, bit 0 at word bit 15
// - all eight subfunction bits are marked meaningful in those formats, none in others
// - B6 uses 48-bit immediate index with item count register from R
// - CD/CE take low 24 immediate bits; BE/BF take full 48 bits
// - format 6 index operations take a 16-bit immediate operand
// - operation 33 takes a 6-bit immediate flag-register bit number
// - format 4 R and S name arithmetic operand registers
// - formats 5 and 6 R names the destination register, except B6 and 2A
// - format 4 T names the arithmetic result register
// - formats 7,8,9,B T holds base address of result or branch target
// - format A T receives the previous state of a register
// - formats 1 and 3 Y holds offset or index for source B
// - format 2 X, Y, Z hold order vectors for sparse fields A, B, C
// - format 1 Z holds the control vector base gating result C
// - format 3 Z holds the index applied to result field C
// - B0..B5 X and Z supply signed operands from rightmost 48 bits
// - B0..B5 Y holds an index forming the branch target
// - selectors below 80 are 32-bit words, from 80 up 64-bit
// - word bits numbered from leftmost as 0 toward the right
module idd_decoder
  import idd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [63:0] instr_word,
  output logic dec_valid,
  output logic [7:0] dec_opcode,
  output logic dec_defined,
  output logic dec_long_word,
  output idd_fmt_t dec_fmt,
  output logic [7:0] dec_subf,
  output logic [7:0] dec_subf_used,
  output idd_imm_t dec_imm_kind,
  output logic [47:0] dec_imm,
  output logic [5:0] dec_bit_sel,
  output idd_reg_t dec_reg_a,
  output idd_reg_t dec_reg_b,
  output idd_reg_t dec_reg_c,
  output idd_reg_t dec_reg_x,
  output idd_reg_t dec_reg_y,
  output idd_reg_t dec_reg_z,
  output idd_reg_t dec_reg_r,
  output idd_reg_t dec_reg_s,
  output idd_reg_t dec_reg_t,
  output logic [8:0] dec_reg_valid,
  output idd_zrole_t dec_z_role,
  output logic dec_r_is_dest,
  output logic dec_r_item_count,
  output logic dec_t_is_dest,
  output logic dec_t_old_state,
  output logic dec_t_base_addr,
  output logic dec_signed48
);

  // ************************************************************
  // field extraction helpers
  // ************************************************************
  // pull len bits starting at leftmost-numbered position pos
  function automatic logic [47:0] fld(input logic [63:0] w, input logic [7:0] pos,
                                      input logic [7:0] len);
    logic [63:0] sh;
    logic [63:0] m;
    logic [7:0] amt;
    amt = 8'(`IDD_WORD_BITS - pos - len);
    sh = w >> amt;
    m = (64'h1 << len) - 64'h1;
    sh = sh & m;
    return sh[47:0];
  endfunction

  // one 8-bit register designator, used as a direct file index
  function automatic idd_reg_t reg_at(input logic [63:0] w, input logic [7:0] pos);
    logic [47:0] v;
    v = fld(w, pos, `IDD_LEN_BYTE);
    return v[7:0];
  endfunction

  // ************************************************************
  // format lookup
  // ************************************************************
  idd_fmt_if fmt_bus ();

  idd_fmt_lookup u_lookup (
    .fmt_bus (fmt_bus.lookup)
  );

  idd_state_t state_ff;
  idd_state_t nxt_state;
  logic [63:0] word_l;
  logic [47:0] f_tmp;

  // short words sit left-justified; the low half is ignored for them
  always_comb
  begin
    word_l = instr_word;
    if (!fmt_bus.long_word)
      word_l[31:0] = 32'h0000_0000;
  end

  // selector from leftmost byte
  always_comb
  begin
    f_tmp = fld(instr_word, `IDD_POS_FUNC, `IDD_LEN_BYTE);
    fmt_bus.opcode = f_tmp[7:0];
  end

  // ************************************************************
  // decode
  // ************************************************************
  // next state from the presented word
  always_comb
  begin
    logic [47:0] s_tmp;
    logic [47:0] i_tmp;
    s_tmp = 48'h0;
    i_tmp = 48'h0;
    nxt_state = state_ff;
    nxt_state.valid = instr_valid;
    if (instr_valid)
    begin
      nxt_state = '0;
      nxt_state.valid = 1'b1;
      nxt_state.opcode = fmt_bus.opcode;
      nxt_state.defined = fmt_bus.defined;
      nxt_state.long_word = fmt_bus.long_word;
      nxt_state.fmt = fmt_bus.fmt;
      nxt_state.subf_used = fmt_bus.subf_used;
      // unused areas are trusted to be zero, no check here
      case (fmt_bus.fmt)
        // vector, sparse vector, string and compare-branch layouts
        IDD_FMT_1, IDD_FMT_2, IDD_FMT_3, IDD_FMT_C:
        begin
          s_tmp = fld(word_l, `IDD_POS_SUBF, `IDD_LEN_BYTE);
          nxt_state.subf = s_tmp[7:0] & fmt_bus.subf_used;
          nxt_state.reg_x = reg_at(word_l, `IDD_POS_REG2);
          nxt_state.reg_a = reg_at(word_l, `IDD_POS_REG3);
          nxt_state.reg_y = reg_at(word_l, `IDD_POS_REG4);
          nxt_state.reg_b = reg_at(word_l, `IDD_POS_REG5);
          nxt_state.reg_z = reg_at(word_l, `IDD_POS_REG6);
          nxt_state.reg_c = reg_at(word_l, `IDD_POS_REG7);
          nxt_state.reg_valid[`IDD_RV_X] = 1'b1;
          nxt_state.reg_valid[`IDD_RV_Y] = 1'b1;
          nxt_state.reg_valid[`IDD_RV_Z] = 1'b1;
          nxt_state.reg_valid[`IDD_RV_A] = 1'b1;
          nxt_state.reg_valid[`IDD_RV_B] = 1'b1;
          nxt_state.reg_valid[`IDD_RV_C] = 1'b1;
          case (fmt_bus.fmt)
            IDD_FMT_1: nxt_state.z_role = IDD_Z_CTLVEC;
            IDD_FMT_2: nxt_state.z_role = IDD_Z_ORDVEC;
            IDD_FMT_3: nxt_state.z_role = IDD_Z_RESIDX;
            default:
            begin
              // compare branches: x and z signed 48-bit, y target index
              nxt_state.z_role = IDD_Z_CMPOPND;
              nxt_state.signed48 = 1'b1;
            end
          endcase
        end
        // three-register arithmetic layout
        IDD_FMT_4:
        begin
          nxt_state.reg_r = reg_at(word_l, `IDD_POS_REG1);
          nxt_state.reg_s = reg_at(word_l, `IDD_POS_REG2);
          nxt_state.reg_t = reg_at(word_l, `IDD_POS_REG3);
          nxt_state.reg_valid[`IDD_RV_R] = 1'b1;
          nxt_state.reg_valid[`IDD_RV_S] = 1'b1;
          nxt_state.reg_valid[`IDD_RV_T] = 1'b1;
          nxt_state.t_is_dest = 1'b1;
        end
        // register plus long immediate
        IDD_FMT_5:
        begin
          nxt_state.reg_r = reg_at(word_l, `IDD_POS_REG1);
          nxt_state.reg_valid[`IDD_RV_R] = 1'b1;
          if (fmt_bus.opcode == `IDD_OP_B6)
          begin
            i_tmp = fld(word_l, `IDD_POS_IMM, `IDD_LEN_IMM48);
            nxt_state.imm = i_tmp;
            nxt_state.imm_kind = IDD_IMM_BRIDX48;
            nxt_state.r_item_count = 1'b1;
          end
          else if (fmt_bus.opcode == `IDD_OP_CD || fmt_bus.opcode == `IDD_OP_CE)
          begin
            i_tmp = fld(word_l, `IDD_POS_IMM + `IDD_LEN_IMM24, `IDD_LEN_IMM24);
            nxt_state.imm = i_tmp;
            nxt_state.imm_kind = IDD_IMM_OPND24;
            nxt_state.r_is_dest = 1'b1;
          end
          else
          begin
            i_tmp = fld(word_l, `IDD_POS_IMM, `IDD_LEN_IMM48);
            nxt_state.imm = i_tmp;
            nxt_state.imm_kind = IDD_IMM_OPND48;
            nxt_state.r_is_dest = 1'b1;
          end
        end
        // register plus short immediate
        IDD_FMT_6:
        begin
          nxt_state.reg_r = reg_at(word_l, `IDD_POS_REG1);
          nxt_state.reg_valid[`IDD_RV_R] = 1'b1;
          i_tmp = fld(word_l, `IDD_POS_IMM, `IDD_LEN_IMM16);
          nxt_state.imm = i_tmp;
          nxt_state.imm_kind = IDD_IMM_OPND16;
          // the register operation of this layout has its own meaning for r
          nxt_state.r_is_dest = (fmt_bus.opcode != `IDD_OP_2A);
        end
        // branch and nontypical layouts with r, s, t
        IDD_FMT_7, IDD_FMT_8, IDD_FMT_A:
        begin
          nxt_state.reg_r = reg_at(word_l, `IDD_POS_REG1);
          nxt_state.reg_s = reg_at(word_l, `IDD_POS_REG2);
          nxt_state.reg_t = reg_at(word_l, `IDD_POS_REG3);
          nxt_state.reg_valid[`IDD_RV_R] = 1'b1;
          nxt_state.reg_valid[`IDD_RV_S] = 1'b1;
          nxt_state.reg_valid[`IDD_RV_T] = 1'b1;
          if (fmt_bus.fmt == IDD_FMT_A)
          begin
            nxt_state.t_old_state = 1'b1;
            nxt_state.t_is_dest = 1'b1;
          end
          else
            nxt_state.t_base_addr = 1'b1;
        end
        // subfunction, s and t branch layout
        IDD_FMT_9:
        begin
          s_tmp = fld(word_l, `IDD_POS_SUBF, `IDD_LEN_BYTE);
          nxt_state.subf = s_tmp[7:0] & fmt_bus.subf_used;
          nxt_state.reg_s = reg_at(word_l, `IDD_POS_REG2);
          nxt_state.reg_t = reg_at(word_l, `IDD_POS_REG3);
          nxt_state.reg_valid[`IDD_RV_S] = 1'b1;
          nxt_state.reg_valid[`IDD_RV_T] = 1'b1;
          nxt_state.t_base_addr = 1'b1;
        end
        // flag-bit branch layout
        IDD_FMT_B:
        begin
          s_tmp = fld(word_l, `IDD_POS_SUBF, `IDD_LEN_BYTE);
          nxt_state.subf = s_tmp[7:0] & fmt_bus.subf_used;
          i_tmp = fld(word_l, `IDD_POS_BITSEL, `IDD_LEN_BITSEL);
          nxt_state.bit_sel = i_tmp[5:0];
          nxt_state.imm = i_tmp;
          nxt_state.imm_kind = IDD_IMM_BITSEL;
          nxt_state.reg_t = reg_at(word_l, `IDD_POS_REG3);
          nxt_state.reg_valid[`IDD_RV_T] = 1'b1;
          nxt_state.t_base_addr = 1'b1;
        end
        default:
        begin
          // undefined selector: only selector, word length and class are reported
          nxt_state.fmt = IDD_FMT_NONE;
        end
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  // one register holds every decoded field
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // all fields straight from the state register
  assign dec_valid = state_ff.valid;
  assign dec_opcode = state_ff.opcode;
  assign dec_defined = state_ff.defined;
  assign dec_long_word = state_ff.long_word;
  assign dec_fmt = state_ff.fmt;
  assign dec_subf = state_ff.subf;
  assign dec_subf_used = state_ff.subf_used;
  assign dec_imm_kind = state_ff.imm_kind;
  assign dec_imm = state_ff.imm;
  assign dec_bit_sel = state_ff.bit_sel;
  assign dec_reg_a = state_ff.reg_a;
  assign dec_reg_b = state_ff.reg_b;
  assign dec_reg_c = state_ff.reg_c;
  assign dec_reg_x = state_ff.reg_x;
  assign dec_reg_y = state_ff.reg_y;
  assign dec_reg_z = state_ff.reg_z;
  assign dec_reg_r = state_ff.reg_r;
  assign dec_reg_s = state_ff.reg_s;
  assign dec_reg_t = state_ff.reg_t;
  assign dec_reg_valid = state_ff.reg_valid;
  assign dec_z_role = state_ff.z_role;
  assign dec_r_is_dest = state_ff.r_is_dest;
  assign dec_r_item_count = state_ff.r_item_count;
  assign dec_t_is_dest = state_ff.t_is_dest;
  assign dec_t_old_state = state_ff.t_old_state;
  assign dec_t_base_addr = state_ff.t_base_addr;
  assign dec_signed48 = state_ff.signed48;

endmodule // idd_decoder
`default_nettype wire

// file: verif/idd_decoder_assertions.sv
`default_nettype none
module idd_decoder_assertions
  import idd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [63:0] instr_word,
  input wire logic dec_valid,
  input wire logic [7:0] dec_opcode,
  input wire logic dec_defined,
  input wire logic dec_long_word,
  input wire idd_fmt_t dec_fmt,
  input wire logic [7:0] dec_subf,
  input wire logic [7:0] dec_subf_used,
  input wire idd_imm_t dec_imm_kind,
  input wire logic [47:0] dec_imm,
  input wire logic [5:0] dec_bit_sel,
  input wire idd_reg_t dec_reg_t,
  input wire logic [8:0] dec_reg_valid,
  input wire logic dec_r_item_count,
  input wire logic dec_t_is_dest
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ***************************************************************
  // steps: a word taken, then its answer
  // ***************************************************************
  sequence s_take;
    instr_valid ##1 dec_valid;
  endsequence
  sequence s_def;
    s_take ##0 dec_defined;
  endsequence

  property p_answer;
    instr_valid |=> dec_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_quiet;
    !instr_valid |=> !dec_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray answer");
  property p_opcode;
    s_def |-> dec_opcode == $past(instr_word[63:56]);
  endproperty
  a_opcode: assert property (p_opcode) else $error("selector wrong");
  property p_long;
    s_def |-> dec_long_word == $past(instr_word[63]);
  endproperty
  a_long: assert property (p_long) else $error("word length wrong");
  property p_undef;
    dec_valid && !dec_defined |-> dec_fmt == IDD_FMT_NONE && dec_reg_valid == 9'h000;
  endproperty
  a_undef: assert property (p_undef) else $error("unused selector decoded");
  property p_gused;
    dec_valid |-> dec_subf_used == ((dec_fmt inside {IDD_FMT_1, IDD_FMT_2, IDD_FMT_3,
      IDD_FMT_9, IDD_FMT_B, IDD_FMT_C}) ? 8'hFF : 8'h00);
  endproperty
  a_gused: assert property (p_gused) else $error("use mask wrong");
  property p_subf;
    s_take ##0 (dec_subf_used == 8'hFF) |-> dec_subf == $past(instr_word[55:48]);
  endproperty
  a_subf: assert property (p_subf) else $error("subfunction wrong");
  property p_b6;
    s_def ##0 (dec_opcode == 8'hB6) |-> dec_imm_kind == IDD_IMM_BRIDX48
      && dec_r_item_count && dec_imm == $past(instr_word[47:0]);
  endproperty
  a_b6: assert property (p_b6) else $error("index immediate wrong");
  property p_imm24;
    s_def ##0 (dec_opcode inside {8'hCD, 8'hCE}) |->
      dec_imm == {24'h000000, $past(instr_word[23:0])};
  endproperty
  a_imm24: assert property (p_imm24) else $error("24-bit operand wrong");
  property p_imm16;
    s_def ##0 (dec_opcode inside {8'h3E, 8'h3F, 8'h4D, 8'h4E}) |->
      dec_imm == {32'h00000000, $past(instr_word[47:32])};
  endproperty
  a_imm16: assert property (p_imm16) else $error("16-bit operand wrong");
  property p_bitsel;
    s_def ##0 (dec_opcode == 8'h33) |-> dec_bit_sel == $past(instr_word[45:40]);
  endproperty
  a_bitsel: assert property (p_bitsel) else $error("flag bit number wrong");
  property p_fmt4t;
    s_take ##0 (dec_fmt == IDD_FMT_4) |-> dec_t_is_dest && dec_reg_t == $past(instr_word[39:32]);
  endproperty
  a_fmt4t: assert property (p_fmt4t) else $error("result register wrong");
endmodule // idd_decoder_assertions

bind idd_decoder idd_decoder_assertions u_chk (
  .ref_clk, .reset, .instr_valid, .instr_word, .dec_valid, .dec_opcode, .dec_defined,
  .dec_long_word, .dec_fmt, .dec_subf, .dec_subf_used, .dec_imm_kind, .dec_imm,
  .dec_bit_sel, .dec_reg_t, .dec_reg_valid, .dec_r_item_count, .dec_t_is_dest
);
`default_nettype wire

// file: verif/idd_fetch_model.sv
`default_nettype none
module idd_fetch_model
(
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [63:0] word_in,
  output logic instr_valid,
  output logic [63:0] instr_word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [63:0] clean;
  logic [63:0] last_ff = 64'h0;
  // ***************************************************************
  // word source
  // ***************************************************************
  // clear the unused areas of each word
  always_comb
  begin
    clean = word_in;
    if (!word_in[63])
      clean[31:0] = 32'h00000000;
    if (word_in[63:56] == 8'h33)
      clean[47:46] = 2'h0;
  end
  // last word handed over
  always @(posedge ref_clk)
    if (go)
      last_ff <= clean;
  // idle lines show its inverse
  assign instr_valid = go;
  assign instr_word = go ? clean : ~last_ff;
endmodule // idd_fetch_model
`default_nettype wire

// file: verif/tb_instruction_designator_decode.sv
`default_nettype none
module tb_instruction_designator_decode
  import idd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, reset, go, instr_valid, pend_v, have;
  logic [63:0] word_in, instr_word, pend_w;
  wire idd_state_t s;
  int err_total = 0, n_compared = 0;

  idd_fetch_model u_src (.ref_clk, .go, .word_in, .instr_valid, .instr_word);
  idd_decoder u_dut (.ref_clk, .reset, .instr_valid,
    .instr_word, .dec_valid(s.valid), .dec_opcode(s.opcode),
    .dec_defined(s.defined), .dec_long_word(s.long_word), .dec_fmt(s.fmt),
    .dec_subf(s.subf), .dec_subf_used(s.subf_used), .dec_imm_kind(s.imm_kind),
    .dec_imm(s.imm), .dec_bit_sel(s.bit_sel), .dec_reg_a(s.reg_a), .dec_reg_b(s.reg_b),
    .dec_reg_c(s.reg_c), .dec_reg_x(s.reg_x), .dec_reg_y(s.reg_y), .dec_reg_z(s.reg_z),
    .dec_reg_r(s.reg_r), .dec_reg_s(s.reg_s), .dec_reg_t(s.reg_t),
    .dec_reg_valid(s.reg_valid), .dec_z_role(s.z_role), .dec_r_is_dest(s.r_is_dest),
    .dec_r_item_count(s.r_item_count), .dec_t_is_dest(s.t_is_dest),
    .dec_t_old_state(s.t_old_state), .dec_t_base_addr(s.t_base_addr),
    .dec_signed48(s.signed48));

  // ***************************************************************
  // reference model
  // ***************************************************************
  function automatic idd_fmt_t fmt_of(logic [7:0] op);
    case (op) inside
      8'h00, [8'h03:8'h05], [8'h08:8'h0A], [8'h0C:8'h0F], 8'h3D: return IDD_FMT_4;
      8'h06, [8'h12:8'h14]: return IDD_FMT_7;
      8'h10, 8'h11: return IDD_FMT_A;
      8'h32: return IDD_FMT_9;
      8'h33: return IDD_FMT_B;
      8'h2A, 8'h3E, 8'h3F, 8'h4D, 8'h4E: return IDD_FMT_6;
      8'hB6, 8'hBE, 8'hBF, 8'hCD, 8'hCE: return IDD_FMT_5;
      [8'hB0:8'hB5]: return IDD_FMT_C;
      [8'hA0:8'hAF]: return IDD_FMT_2;
      default: return IDD_FMT_NONE;
    endcase
  endfunction

  function automatic idd_state_t model(logic [63:0] w);
    idd_state_t e;
    logic [7:0] op;
    e = '0;
    op = w[63:56];
    e.opcode = op;
    e.long_word = op[7];
    e.fmt = fmt_of(op);
    if (e.fmt == IDD_FMT_NONE)
      return e;
    e.defined = 1'b1;
    if (e.fmt inside {IDD_FMT_2, IDD_FMT_9, IDD_FMT_B, IDD_FMT_C})
    begin
      e.subf = w[55:48];
      e.subf_used = 8'hFF;
    end
    case (e.fmt)
      IDD_FMT_4, IDD_FMT_7, IDD_FMT_A:
      begin
        {e.reg_r, e.reg_s, e.reg_t} = w[55:32];
        e.reg_valid = 9'h1C0;
        e.t_is_dest = e.fmt != IDD_FMT_7;
        e.t_old_state = e.fmt == IDD_FMT_A;
        e.t_base_addr = e.fmt == IDD_FMT_7;
      end
      IDD_FMT_5, IDD_FMT_6:
      begin
        e.reg_r = w[55:48];
        e.reg_valid = 9'h040;
        e.r_is_dest = !(op inside {8'h2A, 8'hB6});
        e.r_item_count = op == 8'hB6;
        e.imm_kind = e.fmt == IDD_FMT_6 ? IDD_IMM_OPND16 : op == 8'hB6 ? IDD_IMM_BRIDX48
          : op inside {8'hCD, 8'hCE} ? IDD_IMM_OPND24 : IDD_IMM_OPND48;
        e.imm = e.fmt == IDD_FMT_6 ? 48'(w[47:32]) : op inside {8'hCD, 8'hCE} ? 48'(w[23:0])
          : w[47:0];
      end
      IDD_FMT_9, IDD_FMT_B:
      begin
        e.reg_t = w[39:32];
        e.t_base_addr = 1'b1;
        e.imm_kind = e.fmt == IDD_FMT_B ? IDD_IMM_BITSEL : IDD_IMM_NONE;
        if (e.fmt == IDD_FMT_9)
          {e.reg_s, e.reg_valid} = {w[47:40], 9'h180};
        else
          {e.bit_sel, e.imm, e.reg_valid} = {w[45:40], 42'h0, w[45:40], 9'h100};
      end
      default:
      begin
        {e.reg_x, e.reg_a, e.reg_y, e.reg_b, e.reg_z, e.reg_c} = w[47:0];
        e.reg_valid = 9'h03F;
        e.z_role = e.fmt == IDD_FMT_2 ? IDD_Z_ORDVEC : IDD_Z_CMPOPND;
        e.signed48 = e.fmt == IDD_FMT_C;
      end
    endcase
    return e;
  endfunction

  // ***************************************************************
  // comparison and closing
  // ***************************************************************
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cmp(input idd_state_t e);
    chk("opcode", s.opcode, e.opcode);
    chk("long_word", s.long_word, e.long_word);
    chk("bit_sel", s.bit_sel, e.bit_sel);
    chk("imm", s.imm, e.imm);
    chk("reg_valid", s.reg_valid, e.reg_valid);
    chk("defined", s.defined, e.defined);
    chk("fmt", s.fmt, e.fmt);
    chk("subf", s.subf, e.subf);
    chk("subf_used", s.subf_used, e.subf_used);
    chk("imm_kind", s.imm_kind, e.imm_kind);
    chk("reg_rst", {s.reg_r, s.reg_s, s.reg_t}, {e.reg_r, e.reg_s, e.reg_t});
    chk("reg_xyz", {s.reg_x, s.reg_y, s.reg_z}, {e.reg_x, e.reg_y, e.reg_z});
    chk("reg_abc", {s.reg_a, s.reg_b, s.reg_c}, {e.reg_a, e.reg_b, e.reg_c});
    chk("z_role", s.z_role, e.z_role);
    chk("roles", s[5:0], e[5:0]);
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic send(input logic v, input logic [63:0] w);
    @(negedge ref_clk);
    go = v;
    word_in = w;
  endtask

  // ***************************************************************
  // clock, expectation pipe and checks
  // ***************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // last word taken
  always @(posedge ref_clk or posedge reset)
    if (reset)
      {pend_v, have} <= 2'b00;
    else
    begin
      pend_v <= instr_valid;
      if (instr_valid)
        {pend_w, have} <= {instr_word, 1'b1};
    end
  // compare settled outputs
  always @(negedge ref_clk)
  begin
    #1;
    if (reset)
      chk("reset_out", {s.valid, s.fmt}, 5'h00);
    else
    begin
      chk("valid", s.valid, pend_v);
      if (have)
        cmp(model(pend_w));
    end
  end
  // watchdog
  initial
  begin
    #20000;
    err_total++;
    report_and_stop();
  end

  // ***************************************************************
  // stimulus
  // ***************************************************************
  initial
  begin
    reset = 1'b1;
    go = 1'b0;
    word_in = 64'h0;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    void'($urandom(32'h46fca801));
    // every selector once, back to back
    for (int i = 0; i < 256; i++)
      send(1'b1, {i[7:0], 24'($urandom), $urandom});
    // random words with random gaps
    for (int i = 0; i < 400; i++)
      send(($urandom % 3) != 0, {$urandom, $urandom});
    // reset in mid-run, word waiting at release
    send(1'b1, 64'hB605000000001234);
    @(negedge ref_clk);
    reset = 1'b1;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    send(1'b1, 64'hCD07FFFFFFABCDEF);
    repeat (5) send(1'b0, 64'h0);
    report_and_stop();
  end
endmodule // tb_instruction_designator_decode
`default_nettype wire
